// ===== core/psf_ctrl.sv
// Purpose: serial control port, register file, fsk and power-down logic
// Assumes: pins synchronous to mclk; serial clock well below mclk/2
// Notes: completed writes queue in a fifo drained after power-on reset
`timescale 1ns/1ps

// ****************************************
// write fifo
// ****************************************
module psf_fifo #(
	parameter int W = 30,
	parameter int D = 16
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} psf_fifo_st_t;
	psf_fifo_st_t q, n;
	logic push, pop;

	assign in_ready = (q.cnt != (AW+1)'(D));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		n = q;
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = q.wp + 1'b1;
		end
		if (pop) begin
			n.rp = q.rp + 1'b1;
		end
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (srst) begin
			n = '0;
		end
	end

	always_ff @(posedge mclk) begin
		q <= n;
	end
endmodule : psf_fifo

// ****************************************
// control port top
// ****************************************
module psf_ctrl #(
	parameter int unsigned POR_CYCLES = psf_pkg::POR_CYCLES
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic port_select,
	input wire logic serial_clk,
	input wire logic serial_in_line,
	input wire logic chip_enable_pin,
	input wire logic lock_indicator,
	input wire logic ref_div_clk,
	output logic lock_or_read_out_pin,
	output logic [psf_pkg::DATA_W-1:0] frac_word,
	output logic [15:0] int_word,
	output logic [13:0] ref_div_ratio,
	output logic dsm_enable,
	output logic prescaler_fixed,
	output logic power_down,
	output logic [psf_pkg::KEEP_N-1:0] block_on,
	output logic fsk_active
);
	import psf_pkg::*;
	localparam int PW = $clog2(POR_CYCLES + 1);

	typedef struct packed {
		psf_frame_t st;
		logic sck;
		logic refc;
		logic [5:0] cnt;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] sh;
		logic rd_drv;
		logic push;
		logic [WORD_W-1:0] push_word;
		logic [9:0] rst;
		logic [13:0] rdiv;
		logic [15:0] intg;
		logic [DATA_W-1:0] frac;
		logic [DATA_W-1:0] seed;
		logic [DATA_W-1:0] cfg;
		logic fsk_bit;
		logic [PW-1:0] por_cnt;
		logic por_done;
		logic out_pin;
		logic [DATA_W-1:0] frac_out;
		logic dsm_en;
		logic pscl_fixed;
		logic pwr_dn;
		logic [KEEP_N-1:0] blk_on;
		logic fsk_go;
	} psf_st_t;

	psf_st_t q, n;
	logic sck_rise, sck_fall, ref_fall, fsk_go, chip_en;
	logic fifo_ready, wr_valid;
	logic [WORD_W-1:0] wr_word;
	logic wr_take, swrst;

	function automatic logic rise(input logic p, input logic c);
		return ~p & c;
	endfunction : rise

	function automatic psf_st_t dflt(input psf_st_t s);
		psf_st_t r;
		r = s;
		r.rst = RST_RESET;
		r.rdiv = REFDIV_RESET;
		r.intg = INTG_RESET;
		r.frac = FRAC_RESET;
		r.seed = SEED_RESET;
		r.cfg = SDCFG_RESET;
		r.fsk_bit = 1'b0;
		return r;
	endfunction : dflt

	function automatic logic [DATA_W-1:0] read_word(input psf_st_t s);
		case (s.addr)
			ADDR_ID: read_word = PART_VERSION_WORD;
			ADDR_RST: read_word = {14'h0000, s.rst};
			ADDR_REFDIV: read_word = {10'h000, s.rdiv};
			ADDR_INTG: read_word = {8'h00, s.intg};
			ADDR_FRAC: read_word = s.frac;
			ADDR_SEED: read_word = s.seed;
			ADDR_SDCFG: read_word = s.cfg;
			default: read_word = '0;
		endcase
	endfunction : read_word

	// ****************************************
	// edges and derived levels
	// ****************************************
	// sampling at mclk: serial clock must stay under mclk/2, not the full port rate
	assign sck_rise = rise(q.sck, serial_clk);
	assign sck_fall = rise(~q.sck, ~serial_clk);
	assign ref_fall = rise(~q.refc, ~ref_div_clk);
	// fsk data only while no frame is being clocked
	assign fsk_go = q.cfg[CFG_FSK_EN] & port_select & (q.st == ST_IDLE);
	assign chip_en = q.rst[RST_PIN_SEL] ? chip_enable_pin : q.rst[RST_SPI_EN];
	// writes wait in the fifo until power-on reset has finished
	assign wr_take = wr_valid & q.por_done;
	assign swrst = wr_take && wr_word[WORD_W-1 -: ADDR_W] == ADDR_STROBE
		&& wr_word[STROBE_SWRST];

	psf_fifo #(
		.W(WORD_W),
		.D(FIFO_DEPTH)
	) u_psf_fifo (
		.mclk(mclk),
		.srst(srst),
		.in_valid(q.push),
		.in_ready(fifo_ready),
		.in_data(q.push_word),
		.out_valid(wr_valid),
		.out_ready(q.por_done),
		.out_data(wr_word)
	);

	always_comb begin
		n = q;
		n.sck = serial_clk;
		n.refc = ref_div_clk;
		n.push = q.push & ~fifo_ready;
		// ****************************************
		// frame engine
		// ****************************************
		case (q.st)
			ST_IDLE: begin
				n.cnt = '0;
				n.rd_drv = 1'b0;
				if (port_select && sck_rise) begin
					n.cnt = 6'h01;
					n.rd = serial_in_line;
					n.st = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (sck_fall && q.cnt == EDGE_FRAME_END) begin
					// host ends the frame on the 32nd falling edge
					n.st = ST_DONE;
					if (!q.rd) begin
						n.push = 1'b1;
						n.push_word = {q.addr, q.sh};
					end
				end else if (!port_select) begin
					n.st = ST_IDLE;
					n.rd_drv = 1'b0;
				end else if (sck_rise) begin
					n.cnt = q.cnt + 6'h01;
					if (q.cnt < EDGE_ADDR_LAST) begin
						n.addr = {q.addr[ADDR_W-2:0], serial_in_line};
					end else if (q.cnt < EDGE_DATA_LAST) begin
						if (!q.rd) begin
							n.sh = {q.sh[DATA_W-2:0], serial_in_line};
						end else if (q.cnt == EDGE_ADDR_LAST) begin
							n.sh = read_word(q);
							n.rd_drv = 1'b1;
						end else begin
							n.sh = {q.sh[DATA_W-2:0], 1'b0};
						end
					end else begin
						n.rd_drv = 1'b0;
					end
				end
			end
			ST_DONE: begin
				n.rd_drv = 1'b0;
				if (!port_select) begin
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// ****************************************
		// register writes from the fifo
		// ****************************************
		if (wr_take) begin
			case (wr_word[WORD_W-1 -: ADDR_W])
				ADDR_RST: n.rst = wr_word[9:0];
				ADDR_REFDIV: n.rdiv = wr_word[13:0];
				ADDR_INTG: n.intg = wr_word[15:0];
				ADDR_FRAC: n.frac = wr_word[DATA_W-1:0];
				ADDR_SEED: n.seed = wr_word[DATA_W-1:0];
				ADDR_SDCFG: n.cfg = wr_word[DATA_W-1:0];
				default: n.cfg = q.cfg;
			endcase
		end
		// ****************************************
		// fsk sampling
		// ****************************************
		n.fsk_go = fsk_go;
		if (!fsk_go) begin
			n.fsk_bit = 1'b0;
		end else if (ref_fall) begin
			n.fsk_bit = serial_in_line;
		end
		// ****************************************
		// power-on and soft reset
		// ****************************************
		if (!q.por_done) begin
			n = dflt(n);
			n.por_cnt = q.por_cnt + PW'(1);
			n.por_done = (q.por_cnt == PW'(POR_CYCLES - 1));
		end
		if (swrst) begin
			n = dflt(n);
		end
		// ****************************************
		// outputs
		// ****************************************
		// modulus 2^24 wraps through the 24-bit sum
		n.frac_out = q.fsk_bit ? q.frac + q.seed : q.frac;
		n.dsm_en = q.cfg[CFG_FRAC_RSTB] | q.cfg[CFG_BUFF_RSTB];
		n.pscl_fixed = ~n.dsm_en;
		n.pwr_dn = ~chip_en;
		for (int i = 0; i < KEEP_N; i++) begin
			n.blk_on[i] = chip_en | q.rst[RST_KEEP_LO + i];
		end
		// read data stays off the pin while powered down
		n.out_pin = (n.rd_drv && !q.pwr_dn) ? n.sh[DATA_W-1] : lock_indicator;
		if (srst) begin
			n = dflt('0);
		end
	end

	always_ff @(posedge mclk) begin
		q <= n;
	end

	assign lock_or_read_out_pin = q.out_pin;
	assign frac_word = q.frac_out;
	assign int_word = q.intg;
	assign ref_div_ratio = q.rdiv;
	assign dsm_enable = q.dsm_en;
	assign prescaler_fixed = q.pscl_fixed;
	assign power_down = q.pwr_dn;
	assign block_on = q.blk_on;
	assign fsk_active = q.fsk_go;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	a_fsk_one_sum: assert property (q.fsk_bit |=> frac_word == $past(DATA_W'(q.frac + q.seed)))
		else $error("fsk one bit not using frac plus seed");
	a_fsk_stop_base: assert property (!port_select |=> !q.fsk_bit
		##1 frac_word == $past(q.frac))
		else $error("fsk did not return to base frequency");
	a_fsk_sample_edge: assert property ($rose(q.fsk_bit) |-> $past(ref_fall && fsk_go))
		else $error("fsk bit taken off the reference falling edge");
	a_int_mode_path: assert property (!(q.cfg[CFG_FRAC_RSTB] | q.cfg[CFG_BUFF_RSTB])
		|=> prescaler_fixed && !dsm_enable)
		else $error("integer mode did not stop the modulator");
	a_por_hold: assert property (!q.por_done |-> q.intg == INTG_RESET && !wr_take)
		else $error("registers changed before power-on reset ended");
	a_soft_reset: assert property (swrst |=> q.intg == INTG_RESET && q.rst == RST_RESET)
		else $error("soft reset did not restore defaults");
	a_pd_pin: assert property (q.rst[RST_PIN_SEL] && !chip_enable_pin |=> power_down)
		else $error("enable pin low did not power down");
	a_pd_spi: assert property (!q.rst[RST_PIN_SEL] |=> power_down == !$past(q.rst[RST_SPI_EN]))
		else $error("register enable not followed");
	a_keep_on: assert property (power_down |-> block_on == $past(q.rst[RST_KEEP_LO +: KEEP_N]))
		else $error("keep-on option not honoured");
	a_pd_no_read: assert property (q.pwr_dn |=> lock_or_read_out_pin == $past(lock_indicator))
		else $error("read data driven while powered down");
	a_read_id: assert property (q.st == ST_FRAME && q.rd && port_select && sck_rise
		&& q.cnt == EDGE_ADDR_LAST && q.addr == ADDR_ID |=> q.sh == PART_VERSION_WORD)
		else $error("identification word not loaded");
	a_read_restore: assert property (q.st == ST_FRAME && q.rd && port_select && sck_rise
		&& q.cnt == EDGE_DATA_LAST |=> !q.rd_drv)
		else $error("lock indicator not restored at edge 32");
	a_frame_discard: assert property (q.st == ST_FRAME && !port_select
		&& !(sck_fall && q.cnt == EDGE_FRAME_END) |=> !q.push || $past(q.push))
		else $error("partial frame committed");

	c_write_frame: cover property (q.st == ST_FRAME && !q.rd ##1 q.st == ST_DONE);
	c_read_frame: cover property (q.rd_drv ##[1:200] !q.rd_drv);
	c_fsk_one: cover property ($rose(q.fsk_bit));
	c_soft_reset: cover property (swrst);
endmodule : psf_ctrl

// ===== core/psf_pkg.sv
// Purpose: shared constants and types of the synthesizer serial control port
// Assumes: one 25 MHz clock, all pins synchronous to it
// Notes: register words are 24 bits, addresses 6 bits
package psf_pkg;
	// ****************************************
	// frame layout
	// ****************************************
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int WORD_W = ADDR_W + DATA_W;
	localparam logic [5:0] EDGE_ADDR_LAST = 6'h07;
	localparam logic [5:0] EDGE_DATA_LAST = 6'h1F;
	localparam logic [5:0] EDGE_FRAME_END = 6'h20;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [5:0] ADDR_ID = 6'h00;
	localparam logic [5:0] ADDR_STROBE = 6'h00;
	localparam logic [5:0] ADDR_RST = 6'h01;
	localparam logic [5:0] ADDR_REFDIV = 6'h02;
	localparam logic [5:0] ADDR_INTG = 6'h03;
	localparam logic [5:0] ADDR_FRAC = 6'h04;
	localparam logic [5:0] ADDR_SEED = 6'h05;
	localparam logic [5:0] ADDR_SDCFG = 6'h06;
	localparam int STROBE_SWRST = 0;
	localparam int RST_PIN_SEL = 0;
	localparam int RST_SPI_EN = 1;
	localparam int RST_KEEP_LO = 2;
	localparam int KEEP_N = 7;
	localparam int CFG_FRAC_RSTB = 11;
	localparam int CFG_BUFF_RSTB = 12;
	localparam int CFG_FSK_EN = 13;
	localparam logic [9:0] RST_RESET = 10'h001;
	localparam logic [13:0] REFDIV_RESET = 14'h0001;
	localparam logic [15:0] INTG_RESET = 16'h00C8;
	localparam logic [23:0] FRAC_RESET = 24'h000000;
	localparam logic [23:0] SEED_RESET = 24'h000000;
	localparam logic [23:0] SDCFG_RESET = 24'h000287;
	// arbitrary neutral identification value
	localparam logic [23:0] PART_VERSION_WORD = 24'hA5C301;
	// ****************************************
	// timing
	// ****************************************
	localparam int MCLK_PERIOD_NS = 40;
	localparam int POR_TIME_NS = 250000;
	localparam int POR_CYCLES = (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} psf_frame_t;
endpackage : psf_pkg

// ===== test/psf_ctrl_tb_top.sv
// Purpose: self-checking bench of the serial control port
// Assumes: power-on count shortened to 8 cycles
// Notes: fixed settle of a few mclk after each write for the fifo drain
`timescale 1ns/1ps
module psf_ctrl_tb_top;
	import psf_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic chip_enable_pin = 1'b1;
	logic lock_indicator = 1'b0;
	logic ref_div_clk = 1'b0;
	logic port_select, serial_clk, serial_in_line, lock_or_read_out_pin;
	logic [23:0] frac_word;
	logic [15:0] int_word;
	logic [13:0] ref_div_ratio;
	logic dsm_enable, prescaler_fixed, power_down, fsk_active;
	logic [6:0] block_on;
	logic [23:0] r;
	int err_count = 0;
	int n_tests = 0;
	always #20 mclk = ~mclk;
	psf_ctrl #(.POR_CYCLES(8)) u_psf_ctrl (.mclk(mclk), .srst(srst),
		.port_select(port_select), .serial_clk(serial_clk), .serial_in_line(serial_in_line),
		.chip_enable_pin(chip_enable_pin), .lock_indicator(lock_indicator),
		.ref_div_clk(ref_div_clk), .lock_or_read_out_pin(lock_or_read_out_pin),
		.frac_word(frac_word), .int_word(int_word), .ref_div_ratio(ref_div_ratio),
		.dsm_enable(dsm_enable), .prescaler_fixed(prescaler_fixed),
		.power_down(power_down), .block_on(block_on), .fsk_active(fsk_active));
	psf_host_model u_psf_host_model (.mclk(mclk), .port_select(port_select),
		.serial_clk(serial_clk), .serial_in_line(serial_in_line),
		.lock_or_read_out_pin(lock_or_read_out_pin));
	// ****************************************
	// helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic wr(input logic [5:0] a, input logic [23:0] d, input int n = 32);
		logic [23:0] x;
		u_psf_host_model.xfer(1'b0, a, d, n, x);
		tick(6);
	endtask : wr
	task automatic fsk_bit(input logic b, input logic [23:0] pre, input logic [23:0] post);
		u_psf_host_model.fsk_drive(1'b1, b);
		tick(2);
		ref_div_clk <= 1'b1;
		tick(3);
		check(frac_word, pre);
		ref_div_clk <= 1'b0;
		tick(3);
		check(frac_word, post);
	endtask : fsk_bit
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_defaults;
		check(int_word, 32'h000000C8);
		check(ref_div_ratio, 32'h00000001);
		check(frac_word, 32'h00000000);
		check({dsm_enable, prescaler_fixed}, 32'h00000001);
		check({power_down, block_on}, 32'h0000007F);
	endtask : t_defaults
	task automatic t_id_read;
		lock_indicator <= 1'b1;
		u_psf_host_model.xfer(1'b1, ADDR_ID, 24'h000000, 32, r);
		check(r, PART_VERSION_WORD);
		tick(2);
		check(lock_or_read_out_pin, 32'h00000001);
	endtask : t_id_read
	task automatic t_write_read;
		wr(ADDR_FRAC, 24'h80A5C1);
		check(frac_word, 32'h0080A5C1);
		u_psf_host_model.xfer(1'b1, ADDR_FRAC, 24'h000000, 32, r);
		check(r, 32'h0080A5C1);
		wr(ADDR_INTG, 24'h00005C);
		check(int_word, 32'h0000005C);
		wr(ADDR_REFDIV, 24'h002B3C);
		check(ref_div_ratio, 32'h00002B3C);
		wr(ADDR_SDCFG, 24'h001A87);
		check({dsm_enable, prescaler_fixed}, 32'h00000002);
	endtask : t_write_read
	task automatic t_abort;
		wr(ADDR_FRAC, 24'h000001, 20);
		check(frac_word, 32'h0080A5C1);
		wr(ADDR_FRAC, 24'h123456);
		check(frac_word, 32'h00123456);
	endtask : t_abort
	task automatic t_fsk;
		// seed chosen so the sum wraps past the 24-bit modulus
		wr(ADDR_SEED, 24'hF00000);
		wr(ADDR_SDCFG, 24'h003A87);
		fsk_bit(1'b1, 24'h123456, 24'h023456);
		check(fsk_active, 32'h00000001);
		fsk_bit(1'b0, 24'h023456, 24'h123456);
		fsk_bit(1'b1, 24'h123456, 24'h023456);
		u_psf_host_model.fsk_drive(1'b0, 1'b1);
		tick(3);
		check(frac_word, 32'h00123456);
		check(fsk_active, 32'h00000000);
	endtask : t_fsk
	task automatic t_power;
		chip_enable_pin <= 1'b0;
		lock_indicator <= 1'b0;
		tick(3);
		check({power_down, block_on}, 32'h00000080);
		u_psf_host_model.xfer(1'b1, ADDR_FRAC, 24'h000000, 32, r);
		check(r, 32'h00000000);
		for (int k = 0; k < 7; k++) begin
			wr(ADDR_RST, 24'(32'h00000001 | (32'h00000004 << k)));
			check({power_down, block_on}, 32'h00000080 | (32'h00000001 << k));
		end
		// pin high but register enable clear: must still power down
		chip_enable_pin <= 1'b1;
		wr(ADDR_RST, 24'h000000);
		check({power_down, block_on}, 32'h00000080);
		chip_enable_pin <= 1'b0;
		wr(ADDR_RST, 24'h000002);
		check({power_down, block_on}, 32'h0000007F);
	endtask : t_power
	task automatic t_soft;
		wr(ADDR_STROBE, 24'h000001);
		tick(10);
		check(frac_word, 32'h00000000);
		check(int_word, 32'h000000C8);
		check(ref_div_ratio, 32'h00000001);
		check({power_down, block_on}, 32'h00000080);
	endtask : t_soft
	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		tick(20);
		t_defaults();
		t_id_read();
		t_write_read();
		t_abort();
		t_fsk();
		t_power();
		t_soft();
		final_report();
	end
	// hang guard: the whole run is far below this
	initial begin
		tick(100000);
		err_count++;
		final_report();
	end
endmodule : psf_ctrl_tb_top

// ===== test/psf_host_model.sv
// Purpose: host side of the serial control port, frames and fsk data
// Assumes: serial clock phases of 3 mclk each, well inside the port limit
// Notes: all pins change just after a rising mclk edge
`timescale 1ns/1ps
module psf_host_model (
	input wire logic mclk,
	output logic port_select,
	output logic serial_clk,
	output logic serial_in_line,
	input wire logic lock_or_read_out_pin
);
	initial begin
		port_select = 1'b0;
		serial_clk = 1'b0;
		serial_in_line = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// ****************************************
	// one frame; nbits below 32 aborts it early
	// ****************************************
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] d,
		input int nbits, output logic [23:0] r);
		logic [31:0] w;
		w = {rd, a, d, 1'b0};
		r = 24'h000000;
		@(posedge mclk);
		port_select <= 1'b1;
		for (int i = 0; i < nbits; i++) begin
			serial_in_line <= w[31-i];
			tick(3);
			serial_clk <= 1'b1;
			tick(3);
			if (i >= 7 && i <= 30) r = {r[22:0], lock_or_read_out_pin};
			serial_clk <= 1'b0;
			if (i == 31) port_select <= 1'b0;
		end
		tick(1);
		port_select <= 1'b0;
		// released line: never leave the last bit showing
		serial_in_line <= ~serial_in_line;
		tick(2);
	endtask : xfer
	task automatic fsk_drive(input logic sel, input logic b);
		@(posedge mclk);
		port_select <= sel;
		serial_in_line <= b;
		serial_clk <= 1'b0;
	endtask : fsk_drive
endmodule : psf_host_model
